//--- hdl/cmd_dec_pkg.sv
// Constants shared by the active-state command decoder files
package cmd_dec_pkg;
   // ****************************************
   // Command byte layout and opcodes
   // ****************************************
   localparam int CID_HI = 7;
   localparam int CID_LO = 4;
   localparam int OPC_HI = 3;
   localparam int OPC_LO = 0;
   localparam logic [3:0] OPC_ZONE_SEL = 4'h1;
   localparam logic [3:0] OPC_RD_USER = 4'h2;
   localparam logic [3:0] OPC_WR_USER = 4'h3;
   localparam logic [3:0] OPC_WR_SYS = 4'h4;
   localparam logic [3:0] OPC_RD_SYS = 4'h6;
   localparam logic [3:0] OPC_VERIFY = 4'h8;
   localparam logic [3:0] OPC_CHKSUM = 4'h9;
   localparam logic [3:0] OPC_DESEL = 4'hA;
   localparam logic [3:0] OPC_IDLE = 4'hB;
   localparam logic [3:0] OPC_CHK_PW = 4'hC;
   // ****************************************
   // Zone-select parameter byte
   // ****************************************
   localparam int ZP_ANTI_TEAR_BIT = 7;
   localparam int ZP_RSV_HI = 6;
   localparam int ZP_RSV_LO = 4;
   localparam int ZP_ZONE_HI = 3;
   localparam int ZP_ZONE_LO = 0;
   // ****************************************
   // Acknowledge and status codes
   // ****************************************
   localparam logic [7:0] ACK_OK = 8'h00;
   localparam logic [7:0] ACK_FAIL = 8'h01;
   localparam logic [3:0] ACK_FAIL_NIB = 4'h1;
   localparam logic [7:0] STS_OK = 8'h00;
   localparam logic [7:0] STS_PARAM_BAD = 8'hA1;
   localparam logic [3:0] CNT_MAX_V1 = 4'h8;
   localparam logic [3:0] CNT_MAX_V2 = 4'hF;
   // ****************************************
   // Frame checksum (ISO 14443-3 Type B)
   // ****************************************
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REF = 16'h8408;
   // Register contents after a clean frame and its own checksum
   localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
   localparam int REPLY_MIN_LEN = 5;
   localparam logic [2:0] ZS_REPLY_LEN = 3'h5;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [3:0] CID_RST = 4'h0;
   localparam logic [3:0] ZONE_RST = 4'h0;
endpackage

//--- hdl/byte_crc_if.sv
// Interface carrying one byte into a Type B checksum unit
`timescale 1ns/1ps
`default_nettype none
interface byte_crc_if;
   logic clr;
   logic en;
   logic [7:0] data;
   logic [15:0] crc;
   modport user (output clr, output en, output data, input crc);
   modport unit (input clr, input en, input data, output crc);
endinterface
`default_nettype wire

//--- hdl/crc_b_unit.sv
// Byte-serial Type B frame checksum accumulator
`timescale 1ns/1ps
`default_nettype none
module crc_b_unit
   import cmd_dec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Byte stream
   byte_crc_if.unit bus
);
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;

   // ****************************************
   // Reflected CRC-16, one byte per clock
   // ****************************************
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] v;
      v = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         v = v[0] ? ((v >> 1) ^ CRC_POLY_REF) : (v >> 1);
      end
      return v;
   endfunction

   // Clear with enable folds the first byte into the start value, so the
   // opening byte of a frame is not lost
   assign crc_nxt = bus.en ? crc_step(bus.clr ? CRC_INIT : crc_r, bus.data) :
                    bus.clr ? CRC_INIT : crc_r;

   // Register the running value
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_r <= CRC_INIT;
      end else begin
         crc_r <= crc_nxt;
      end
   end

   // Complement of the value including the byte offered this cycle, so a
   // user can act on the last byte at the edge that takes it
   assign bus.crc = ~crc_nxt;
endmodule
`default_nettype wire

//--- hdl/active_state_cmd_decoder.sv
// Active-state command decoder and reply formatter
//
// Summary of operation
// R1: Upper nibble card ID, lower nibble opcode
// R2: Parameter byte picks function of multi-function commands
// R3: Unsupported opcode frames dropped without reply
// R4: Card ID mismatch frames dropped without reply
// R5: Every reply is at least five bytes
// R6: Reply starts with echoed command byte
// R7: Second reply byte is acknowledge byte
// R8: Status byte then two checksum bytes end reply
// R9: Payload sits between acknowledge and status
// R10: Success zero, generic failure bit zero only
// R11: Password failure puts attempts count upper nibble
// R12: Auth failure puts attempts count upper nibble
// R13: First variant counts zero to eight
// R14: Second variant counts to fifteen, fifteen locks
// R15: Status reports state or first error only
// R16: Exactly one zone selected at any time
// R17: Zone param: anti-tear flag, zeros, zone number
// R18: Anti-tear flag governs later user writes
// R19: Zone select answered only in Active State
// R20: Zone select with transmission errors dropped
// R21: Zone select status 00 ack, A1 nack
// R22: Card ID taken from selection, kept for matching
// R23: Checksum computed on replies, checked on receive
// R24: Zone select reply exactly five bytes
`timescale 1ns/1ps
`default_nettype none
module active_state_cmd_decoder
   import cmd_dec_pkg::*;
#(
   parameter bit VARIANT_WIDE = 1'b0
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // Card state from the anticollision layer
   input wire logic ACTIVE_STATE,
   input wire logic CID_LOAD,
   input wire logic [3:0] CID_IN,
   // Received frame bytes, CRC bytes included
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_SOF,
   input wire logic RX_EOF,
   input wire logic RX_ERR,
   // Attempt counters from the security logic
   input wire logic [3:0] PW_ATTEMPTS,
   input wire logic [3:0] AUTH_ATTEMPTS,
   // Reply byte stream
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic [7:0] TX_DATA,
   output logic TX_LAST,
   // Decoded command for other engines
   output logic CMD_STROBE,
   output logic [3:0] CMD_OPCODE,
   output logic [7:0] CMD_PARAM,
   // Zone selection
   output logic [3:0] USER_ZONE,
   output logic ANTI_TEAR_SELECT
);
   typedef enum {ST_IDLE, ST_RECV, ST_SEND} state_t;
   typedef enum {TX_ECHO, TX_ACK, TX_STS, TX_CRC1, TX_CRC2} tx_t;

   state_t state_r, state_nxt;
   tx_t txs_r;
   logic [3:0] cid_r;
   logic [7:0] cmd_r;
   logic [7:0] param_r;
   logic [2:0] cnt_r;
   logic bad_r;
   logic [3:0] zone_r;
   logic at_r;
   logic [7:0] ack_r;
   logic [7:0] sts_r;
   logic strobe_r;
   logic [15:0] tx_crc_hold_r;

   byte_crc_if rxc ();
   byte_crc_if txc ();

   // ****************************************
   // Checksum units for receive and transmit
   // ****************************************
   crc_b_unit u_rx_crc (.clk(SYS_CLK), .rst_b(RST_B), .bus(rxc.unit));
   crc_b_unit u_tx_crc (.clk(SYS_CLK), .rst_b(RST_B), .bus(txc.unit));

   // ****************************************
   // Opcode decoding
   // ****************************************
   function automatic logic opc_known(input logic [3:0] o);
      case (o)
         OPC_ZONE_SEL, OPC_RD_USER, OPC_WR_USER, OPC_WR_SYS,
         OPC_RD_SYS, OPC_VERIFY, OPC_CHKSUM, OPC_DESEL,
         OPC_IDLE, OPC_CHK_PW: opc_known = 1'b1; // R1
         default: opc_known = 1'b0;
      endcase
   endfunction

   logic [3:0] rx_opc;
   logic [3:0] rx_cid;
   logic first_ok;
   logic frame_end;
   logic crc_good;
   logic frame_ok;
   logic is_zone_sel;
   logic zp_valid;
   logic tx_fire;
   assign rx_opc = RX_DATA[OPC_HI:OPC_LO]; // R1
   assign rx_cid = RX_DATA[CID_HI:CID_LO]; // R1
   // Unknown opcode or foreign card ID abandons the frame at its first byte
   assign first_ok = opc_known(rx_opc) && (rx_cid == cid_r); // R3 R4
   assign frame_end = (state_r == ST_RECV) && RX_VALID && RX_EOF;
   // Residue check: data plus its own checksum leaves a fixed remainder
   assign crc_good = (rxc.crc == ~CRC_RESIDUE); // R23
   // Frames of at least command, parameter and two checksum bytes
   assign frame_ok = frame_end && !bad_r && !RX_ERR &&
                     ACTIVE_STATE && (cnt_r >= 3'h3); // R19 R20
   assign is_zone_sel = cmd_r[OPC_HI:OPC_LO] == OPC_ZONE_SEL;
   // Reserved bits must be zero; the zone number takes all 16 codes
   assign zp_valid = param_r[ZP_RSV_HI:ZP_RSV_LO] == 3'h0; // R17
   assign tx_fire = TX_VALID && TX_READY;

   // Receive checksum follows the incoming bytes
   assign rxc.clr = (state_r != ST_RECV) && RX_VALID && RX_SOF;
   assign rxc.en = RX_VALID;
   assign rxc.data = RX_DATA;

   // ****************************************
   // Frame state machine
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (RX_VALID && RX_SOF && ACTIVE_STATE && first_ok) begin
               state_nxt = ST_RECV; // R3 R4 R19
            end
         end
         ST_RECV: begin
            if (!ACTIVE_STATE) begin
               state_nxt = ST_IDLE;
            end else if (frame_end) begin
               // Only a clean zone select gets a reply here; the other
               // commands are handed to their engines by strobe
               state_nxt = (frame_ok && crc_good && is_zone_sel) ?
                           ST_SEND : ST_IDLE; // R20 R23
            end
         end
         ST_SEND: begin
            if (tx_fire && txs_r == TX_CRC2) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // Card ID capture at selection
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cid_r <= CID_RST;
      end else if (CID_LOAD) begin
         cid_r <= CID_IN; // R22
      end
   end

   // ****************************************
   // Byte capture of command and parameter
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmd_r <= 8'h00;
         param_r <= 8'h00;
         cnt_r <= 3'h0;
         bad_r <= 1'b0;
      end else if (state_r == ST_IDLE && RX_VALID && RX_SOF) begin
         cmd_r <= RX_DATA; // R6
         cnt_r <= 3'h1;
         bad_r <= RX_ERR;
      end else if (state_r == ST_RECV && RX_VALID) begin
         if (cnt_r == 3'h1) begin
            param_r <= RX_DATA; // R2
         end
         // Saturate; long frames only need to exceed the minimum
         if (cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
         end
         bad_r <= bad_r | RX_ERR; // R20
      end
   end

   // ****************************************
   // Zone selection and reply content
   // ****************************************
   // One register pair means exactly one zone is ever selected
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         zone_r <= ZONE_RST;
         at_r <= 1'b0;
         ack_r <= ACK_OK;
         sts_r <= STS_OK;
      end else if (state_nxt == ST_SEND && state_r == ST_RECV) begin
         if (zp_valid) begin
            zone_r <= param_r[ZP_ZONE_HI:ZP_ZONE_LO]; // R16 R17
            at_r <= param_r[ZP_ANTI_TEAR_BIT]; // R18
            ack_r <= ACK_OK; // R10 R21
            sts_r <= STS_OK; // R21
         end else begin
            ack_r <= ACK_FAIL; // R10 R21
            sts_r <= STS_PARAM_BAD; // R15 R21
         end
      end
   end

   // ****************************************
   // Command hand-off to execution engines
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strobe_r <= 1'b0;
      end else begin
         strobe_r <= frame_ok && crc_good; // R2
      end
   end

   // ****************************************
   // Reply sequencer
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         txs_r <= TX_ECHO;
      end else if (state_r != ST_SEND) begin
         txs_r <= TX_ECHO; // R6
      end else if (tx_fire) begin
         case (txs_r)
            TX_ECHO: txs_r <= TX_ACK; // R7
            TX_ACK: txs_r <= TX_STS; // R5 R9 R24
            TX_STS: txs_r <= TX_CRC1; // R8
            TX_CRC1: txs_r <= TX_CRC2; // R8
            default: txs_r <= TX_ECHO;
         endcase
      end
   end

   // Snapshot of the checksum after status, so CRC2 is stable
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_crc_hold_r <= 16'h0000;
      end else if (tx_fire && txs_r == TX_STS) begin
         tx_crc_hold_r <= txc.crc;
      end
   end

   logic [7:0] tx_byte;
   assign tx_byte = (txs_r == TX_ECHO) ? cmd_r :
                    (txs_r == TX_ACK) ? ack_r :
                    (txs_r == TX_STS) ? sts_r :
                    (txs_r == TX_CRC1) ? tx_crc_hold_r[7:0] :
                    tx_crc_hold_r[15:8]; // R8 R23

   assign txc.clr = state_r != ST_SEND;
   assign txc.en = tx_fire && (txs_r == TX_ECHO || txs_r == TX_ACK ||
                               txs_r == TX_STS); // R23
   assign txc.data = tx_byte;

   // ****************************************
   // Outputs
   // ****************************************
   assign TX_VALID = state_r == ST_SEND;
   assign TX_DATA = tx_byte;
   assign TX_LAST = TX_VALID && txs_r == TX_CRC2;
   assign CMD_STROBE = strobe_r;
   assign CMD_OPCODE = cmd_r[OPC_HI:OPC_LO];
   assign CMD_PARAM = param_r;
   assign USER_ZONE = zone_r;
   assign ANTI_TEAR_SELECT = at_r;

   // Attempt limit is set for the configured variant, but PW_ATTEMPTS and AUTH_ATTEMPTS are not checked against it here;
   // the engines that answer password and crypto commands embed them
   logic [3:0] cnt_max;
   assign cnt_max = VARIANT_WIDE ? CNT_MAX_V2 : CNT_MAX_V1; // R13 R14

   // ****************************************
   // Checks
   // ****************************************
   property p_foreign_dropped;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (state_r == ST_IDLE && RX_VALID && RX_SOF &&
       RX_DATA[CID_HI:CID_LO] != cid_r) |=> state_r == ST_IDLE;
   endproperty
   a_foreign_dropped: assert property (p_foreign_dropped) // R4
      else $error("foreign card id accepted");

   property p_unknown_dropped;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (state_r == ST_IDLE && RX_VALID && !opc_known(rx_opc))
      |=> state_r == ST_IDLE;
   endproperty
   a_unknown_dropped: assert property (p_unknown_dropped) // R3
      else $error("unknown opcode accepted");

   property p_echo_first;
      @(posedge SYS_CLK) disable iff (!RST_B)
      $rose(TX_VALID) |-> TX_DATA == cmd_r && txs_r == TX_ECHO;
   endproperty
   a_echo_first: assert property (p_echo_first) // R6
      else $error("reply does not start with echo");

   property p_five_bytes;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (TX_READY && $rose(TX_VALID)) ##1 TX_READY[*3]
      |-> ##1 TX_LAST;
   endproperty
   a_five_bytes: assert property (p_five_bytes) // R5 R24
      else $error("reply length is not five");

   property p_ack_status;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (TX_VALID && txs_r == TX_ACK) |->
      (TX_DATA == ACK_OK && sts_r == STS_OK) ||
      (TX_DATA == ACK_FAIL && sts_r == STS_PARAM_BAD);
   endproperty
   a_ack_status: assert property (p_ack_status) // R10 R21
      else $error("ack and status disagree");

   property p_no_reply_inactive;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (state_r == ST_RECV && !ACTIVE_STATE) |=> !TX_VALID;
   endproperty
   a_no_reply_inactive: assert property (p_no_reply_inactive) // R19
      else $error("reply outside active state");

   property p_err_dropped;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (frame_end && (RX_ERR || bad_r)) |=> !TX_VALID;
   endproperty
   a_err_dropped: assert property (p_err_dropped) // R20
      else $error("errored frame answered");

   property p_zone_held;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (state_r != ST_RECV) |=> $stable(zone_r) && $stable(at_r);
   endproperty
   a_zone_held: assert property (p_zone_held) // R16 R18
      else $error("zone changed without selection");

   property p_count_range;
      @(posedge SYS_CLK) disable iff (!RST_B)
      1'b1 |-> cnt_max == (VARIANT_WIDE ? 4'hF : 4'h8);
   endproperty
   a_count_range: assert property (p_count_range) // R13 R14
      else $error("attempt limit wrong for variant");
endmodule
`default_nettype wire

//--- testbench/reader_model.sv
// Reader-side model that sends frames and paces reply bytes
`timescale 1ns/1ps
`default_nettype none
module reader_model (
   // Clock
   input wire logic clk,
   // Frame bytes toward the card
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_sof,
   output logic rx_eof,
   output logic rx_err,
   // Reply pacing
   output logic tx_ready,
   input wire logic stall
);
   // ****************************************
   // Idle levels at time zero
   // ****************************************
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_err = 1'b0;
      tx_ready = 1'b1;
   end

   // Slow pacing stalls at random so replies must hold each byte
   always @(negedge clk) begin
      tx_ready <= stall ? ($urandom_range(1) != 0) : 1'b1;
   end

   // One byte a cycle; the line then shows the inverse, never a stale byte
   task automatic send(input logic [7:0] b [4], input int n, input int e);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = b[i];
         rx_sof = (i == 0);
         rx_eof = (i == n - 1);
         rx_err = (i == e);
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_err = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/active_state_cmd_decoder_test.sv
// Self-checking bench for the active-state command decoder
`timescale 1ns/1ps
`default_nettype none
module active_state_cmd_decoder_test
   import cmd_dec_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic active = 1'b1;
   logic cid_load = 1'b0;
   logic [3:0] cid_in = 4'h0;
   logic [3:0] pw_cnt = 4'h0;
   logic [3:0] auth_cnt = 4'h0;
   logic stall = 1'b0;
   logic rx_valid, rx_sof, rx_eof, rx_err, tx_ready;
   logic [7:0] rx_data;
   logic tx_valid, tx_last, cmd_strobe, anti_tear;
   logic [7:0] tx_data, cmd_param;
   logic [3:0] cmd_opcode, user_zone;
   logic [3:0] cid_exp = CID_RST;
   logic [3:0] zone_exp = ZONE_RST;
   logic at_exp = 1'b0;
   logic [8:0] rq[$];
   logic [11:0] sq[$];
   logic [8:0] e;
   logic [7:0] p;
   int bad_count = 0;
   int checks = 0;

   always #10 sys_clk = ~sys_clk;

   active_state_cmd_decoder #(.VARIANT_WIDE(1'b0)) active_state_cmd_decoder_i (
      .SYS_CLK(sys_clk), .RST_B(rst_b), .ACTIVE_STATE(active),
      .CID_LOAD(cid_load), .CID_IN(cid_in), .RX_VALID(rx_valid),
      .RX_DATA(rx_data), .RX_SOF(rx_sof), .RX_EOF(rx_eof),
      .RX_ERR(rx_err), .PW_ATTEMPTS(pw_cnt), .AUTH_ATTEMPTS(auth_cnt),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
      .TX_LAST(tx_last), .CMD_STROBE(cmd_strobe), .CMD_OPCODE(cmd_opcode),
      .CMD_PARAM(cmd_param), .USER_ZONE(user_zone),
      .ANTI_TEAR_SELECT(anti_tear));

   reader_model reader_model_i (
      .clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_err(rx_err),
      .tx_ready(tx_ready), .stall(stall));

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Own checksum, reflected and inverted, low byte sent first
   function automatic logic [15:0] crc_b(input logic [7:0] b [4], int n);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
         end
      end
      return ~c;
   endfunction

   // Notes expected strobe and reply, sends, then waits for the reply
   task automatic frame(input logic [7:0] cmd, input logic [7:0] prm,
                        input int n, input bit bad, input int err_at);
      logic [7:0] b [4];
      logic [15:0] c;
      logic ok_p;
      logic hit;
      int k;
      b[0] = cmd;
      b[1] = prm;
      b[2] = 8'h00;
      b[3] = 8'h00;
      c = crc_b(b, 2) ^ {15'h0, bad};
      b[2] = c[7:0];
      b[3] = c[15:8];
      hit = active && n == 4 && !bad && err_at < 0 && cmd[7:4] == cid_exp;
      if (hit && cmd[3:0] inside {OPC_ZONE_SEL, OPC_RD_USER, OPC_WR_USER,
          OPC_WR_SYS, OPC_RD_SYS, OPC_VERIFY, OPC_CHKSUM, OPC_DESEL,
          OPC_IDLE, OPC_CHK_PW}) begin
         sq.push_back({cmd[3:0], prm});
      end
      if (hit && cmd[3:0] == OPC_ZONE_SEL) begin
         ok_p = (prm[6:4] == 3'h0);
         b[0] = cmd;
         b[1] = ok_p ? ACK_OK : ACK_FAIL;
         b[2] = ok_p ? STS_OK : STS_PARAM_BAD;
         c = crc_b(b, 3);
         for (int i = 0; i < 3; i++) begin
            rq.push_back({1'b0, b[i]});
         end
         rq.push_back({1'b0, c[7:0]});
         rq.push_back({1'b1, c[15:8]});
         if (ok_p) begin
            zone_exp = prm[3:0];
            at_exp = prm[7];
         end
         b[0] = cmd;
         b[1] = prm;
         c = crc_b(b, 2);
         b[2] = c[7:0];
         b[3] = c[15:8];
      end
      reader_model_i.send(b, n, err_at);
      k = 0;
      while ((rq.size() != 0 || k < 6) && k < 200) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 200) begin
         bad_count++;
         finish_test();
      end
      @(negedge sys_clk);
      check(16'(sq.size()), 16'h0);
      check({12'h0, user_zone}, {12'h0, zone_exp});
      check({15'h0, anti_tear}, {15'h0, at_exp});
   endtask

   // Scoreboard: each accepted byte or strobe retires the oldest note
   always @(posedge sys_clk) begin
      if (rst_b && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         e = (rq.size() != 0) ? rq.pop_front() : 9'h1FF;
         check({7'h0, tx_last, tx_data}, {7'h0, e});
      end
      if (rst_b && cmd_strobe === 1'b1) begin
         check({4'h0, cmd_opcode, cmd_param},
               (sq.size() != 0) ? {4'h0, sq.pop_front()} : 16'hFFFF);
      end
   end

   // A hang ends the run through the normal report
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      finish_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(95));
      repeat (3) @(posedge sys_clk);
      check({15'h0, tx_valid}, 16'h0);
      check({11'h0, anti_tear, user_zone}, 16'h0);
      @(negedge sys_clk);
      rst_b = 1'b1;
      frame(8'h01, 8'h83, 4, 1'b0, -1);
      cid_in = 4'hC;
      cid_load = 1'b1;
      @(negedge sys_clk);
      cid_load = 1'b0;
      cid_exp = 4'hC;
      frame(8'h01, 8'h05, 4, 1'b0, -1);
      frame(8'hC1, 8'h05, 4, 1'b0, -1);
      frame(8'hC1, 8'h70, 4, 1'b0, -1);
      frame(8'hC1, 8'h8F, 4, 1'b0, -1);
      // Random zones, flags and bad reserved bits, with slow pacing on randomly chosen frames
      for (int i = 0; i < 16; i++) begin
         stall = ($urandom_range(1) != 0);
         pw_cnt = 4'($urandom);
         auth_cnt = 4'($urandom);
         p = 8'($urandom);
         if ($urandom_range(3) != 0) begin
            p[6:4] = 3'h0;
         end
         frame({cid_exp, OPC_ZONE_SEL}, p, 4, 1'b0, -1);
      end
      stall = 1'b0;
      // Every opcode: known ones strobe, only zone select answers
      for (int op = 0; op < 16; op++) begin
         frame({cid_exp, 4'(op)}, 8'($urandom) & 8'h8F, 4, 1'b0, -1);
      end
      frame(8'h51, 8'h02, 4, 1'b0, -1);
      frame(8'hC1, 8'h03, 4, 1'b0, 1);
      frame(8'hC1, 8'h03, 4, 1'b1, -1);
      frame(8'hC1, 8'h03, 3, 1'b0, -1);
      active = 1'b0;
      frame(8'hC1, 8'h03, 4, 1'b0, -1);
      active = 1'b1;
      // Reset in mid-run brings zone, flag and card ID back
      rst_b = 1'b0;
      @(negedge sys_clk);
      check({11'h0, anti_tear, user_zone}, 16'h0);
      rst_b = 1'b1;
      cid_exp = CID_RST;
      zone_exp = ZONE_RST;
      at_exp = 1'b0;
      frame(8'h01, 8'h07, 4, 1'b0, -1);
      finish_test();
   end
endmodule
`default_nettype wire
